// >>> hdl/dtc_map.vh
// register offsets, field positions, reset values and codes of the dual 8-bit timer
`ifndef DTC_MAP_VH
`define DTC_MAP_VH
// timer a registers
`define DTC_A_CNT 8'hCA
`define DTC_A_CTL 8'hCB
`define DTC_A_CCTL0 8'hCC
`define DTC_A_CC0 8'hCD
`define DTC_A_CCTL1 8'hCE
`define DTC_A_CC1 8'hCF
// timer b registers
`define DTC_B_CNT 8'hEA
`define DTC_B_CTL 8'hEB
`define DTC_B_CCTL0 8'hEC
`define DTC_B_CC0 8'hED
`define DTC_B_CCTL1 8'hEE
`define DTC_B_CC1 8'hEF
// shared flag and interrupt registers
`define DTC_FLAG 8'hD8
`define DTC_CPU_FLAG 8'hC0
`define DTC_IEN_ONE 8'hB8
`define DTC_IEN_ZERO 8'hA8
// timer control fields
`define DTC_CTL_DIV_LSB 5
`define DTC_CTL_START 4
`define DTC_CTL_OVF_MASK 3
`define DTC_CTL_CLEAR 2
`define DTC_CTL_RESET 8'h08
// channel control fields
`define DTC_CCTL_MASK 6
`define DTC_CCTL_ACT_LSB 3
`define DTC_CCTL_MODE 2
`define DTC_CCTL_RESET 8'h40
`define DTC_CCTL_WMASK 8'h7F
// counting modes
`define DTC_MODE_FREE 2'h0
`define DTC_MODE_DOWN 2'h1
`define DTC_MODE_MOD 2'h2
`define DTC_MODE_UPDN 2'h3
// compare actions
`define DTC_ACT_SET 3'h0
`define DTC_ACT_CLEAR 3'h1
`define DTC_ACT_TGL 3'h2
`define DTC_ACT_SUPC 3'h3
`define DTC_ACT_CUPS 3'h4
`define DTC_ACT_SCFF 3'h5
`define DTC_ACT_CSZ 3'h6
`define DTC_ACT_INIT 3'h7
// capture edges
`define DTC_CAP_RISE 2'h1
`define DTC_CAP_FALL 2'h2
`define DTC_CAP_BOTH 2'h3
// counter terminal values
`define DTC_ZERO 8'h00
`define DTC_TOP 8'hFF
// global enable bit position
`define DTC_GIE_BIT 7
`endif

// >>> hdl/dtc_timer.v
// dual 8-bit timer with two capture/compare channels each, flags and dma triggers
`timescale 1ns/1ps
`include "dtc_map.vh"

module dtc_timer (
  // clock and reset
  input wire core_clk,
  input wire reset,
  // system tick
  input wire tick,
  // register writes
  input wire [7:0] wdata,
  input wire ctl_we,
  input wire [1:0] cctl_we,
  input wire [1:0] cc_we,
  // synchronised channel inputs
  input wire [1:0] cap_sync,
  // register readback
  output reg [7:0] cnt_q,
  output reg [7:0] ctl_q,
  output reg [15:0] cctl_q,
  output reg [15:0] cc_q,
  // events and pins
  output reg ovf_q,
  output reg [1:0] ch_ev_q,
  output reg [1:0] cc_out_q
);
  reg [6:0] presc_q;
  reg dir_q;
  reg load_q;
  reg [15:0] buf_q;
  reg [1:0] pend_q;
  reg [1:0] cap_prev_q;
  reg [7:0] cnt_d;
  reg dir_d;
  reg ovf_d;
  reg [1:0] match;
  reg [1:0] capt;
  reg [1:0] out_d;
  integer n;
  integer k;

  wire [1:0] mode = ctl_q[1:0];
  wire start = ctl_q[`DTC_CTL_START];
  wire [2:0] div = ctl_q[`DTC_CTL_DIV_LSB +: 3];
  wire [7:0] cc0 = cc_q[7:0];
  wire clear_wr = ctl_we & wdata[`DTC_CTL_CLEAR];
  wire [6:0] div_mask = (7'h7F >> (3'd7 - div)) & 7'h7F;
  // prescaler counts up once per system tick; divided edge when masked bits are all ones
  wire active = tick & ((presc_q & div_mask) == div_mask);
  wire adv = active & start;

  // initial compare output level per action code
  function init_level;
    input [2:0] act;
    begin
      init_level = (act == `DTC_ACT_CLEAR) || (act == `DTC_ACT_CUPS) || (act == `DTC_ACT_CSZ);
    end
  endfunction

  // next compare output level for one channel; a match outranks the zero or top event
  function cmp_next;
    input [2:0] act;
    input cur;
    input hit;
    input zero;
    input top;
    input updn;
    input down;
    begin
      cmp_next = cur;
      case (act)
        `DTC_ACT_SET: if (hit) cmp_next = 1'b1;
        `DTC_ACT_CLEAR: if (hit) cmp_next = 1'b0;
        `DTC_ACT_TGL: if (hit) cmp_next = ~cur;
        `DTC_ACT_SUPC: cmp_next = hit ? (updn ? ~down : 1'b1) : ((zero && !updn) ? 1'b0 : cur);
        `DTC_ACT_CUPS: cmp_next = hit ? (updn ? down : 1'b0) : ((zero && !updn) ? 1'b1 : cur);
        `DTC_ACT_SCFF: cmp_next = hit ? 1'b1 : (top ? 1'b0 : cur);
        `DTC_ACT_CSZ: cmp_next = hit ? 1'b0 : (zero ? 1'b1 : cur);
        default: cmp_next = cur;
      endcase
    end
  endfunction

  // counter next value and overflow event
  always @* begin
    cnt_d = cnt_q;
    dir_d = dir_q;
    ovf_d = 1'b0;
    if (adv) begin
      case (mode)
        `DTC_MODE_FREE: begin
          cnt_d = cnt_q + 8'h01;
          ovf_d = (cnt_d == `DTC_TOP);
        end
        `DTC_MODE_DOWN: begin
          if (load_q) begin
            cnt_d = cc0;
          end else if (cnt_q != `DTC_ZERO) begin
            cnt_d = cnt_q - 8'h01;
            ovf_d = (cnt_d == `DTC_ZERO);
          end
        end
        `DTC_MODE_MOD: begin
          if (cnt_q == cc0 || cnt_q == `DTC_TOP) begin
            cnt_d = `DTC_ZERO;
          end else begin
            cnt_d = cnt_q + 8'h01;
            ovf_d = (cnt_d == `DTC_TOP) && (cnt_q > cc0);
          end
        end
        `DTC_MODE_UPDN: begin
          if (!dir_q) begin
            if (cnt_q < cc0) begin
              cnt_d = cnt_q + 8'h01;
            end else if (cnt_q != `DTC_ZERO) begin
              cnt_d = cnt_q - 8'h01;
              dir_d = 1'b1;
              ovf_d = (cnt_d == `DTC_ZERO);
              if (cnt_d == `DTC_ZERO) dir_d = 1'b0;
            end
          end else begin
            cnt_d = cnt_q - 8'h01;
            if (cnt_d == `DTC_ZERO) begin
              dir_d = 1'b0;
              ovf_d = 1'b1;
            end
          end
        end
        default: cnt_d = cnt_q;
      endcase
    end
  end

  // channel matches, captures and output next levels
  always @* begin
    for (n = 0; n < 2; n = n + 1) begin
      match[n] = adv & cctl_q[n*8+`DTC_CCTL_MODE] & (cnt_d == cc_q[n*8 +: 8]);
      capt[n] = 1'b0;
      if (start && !cctl_q[n*8+`DTC_CCTL_MODE]) begin
        case (cctl_q[n*8 +: 2])
          `DTC_CAP_RISE: capt[n] = cap_sync[n] & ~cap_prev_q[n];
          `DTC_CAP_FALL: capt[n] = ~cap_sync[n] & cap_prev_q[n];
          `DTC_CAP_BOTH: capt[n] = cap_sync[n] ^ cap_prev_q[n];
          default: capt[n] = 1'b0;
        endcase
      end
      out_d[n] = cmp_next(cctl_q[n*8+`DTC_CCTL_ACT_LSB +: 3], cc_out_q[n], match[n],
                          adv & (cnt_d == `DTC_ZERO), adv & (cnt_d == `DTC_TOP),
                          mode == `DTC_MODE_UPDN, dir_q);
    end
  end

  always @(posedge core_clk) begin
    if (reset) begin
      presc_q <= 7'h00;
      cnt_q <= `DTC_ZERO;
      dir_q <= 1'b0;
      load_q <= 1'b0;
      ctl_q <= `DTC_CTL_RESET;
      cctl_q <= {2{`DTC_CCTL_RESET}};
      cc_q <= 16'h0000;
      buf_q <= 16'h0000;
      pend_q <= 2'b00;
      cap_prev_q <= 2'b00;
      ovf_q <= 1'b0;
      ch_ev_q <= 2'b00;
      cc_out_q <= 2'b00;
    end else begin
      if (tick) presc_q <= presc_q + 7'h01;
      cap_prev_q <= cap_sync;
      ovf_q <= ovf_d & ~clear_wr;
      cnt_q <= cnt_d;
      dir_q <= dir_d;
      if (adv) load_q <= 1'b0;
      if (ctl_we) begin
        // clear bit is a strobe only, never stored
        ctl_q <= wdata & ~(8'h01 << `DTC_CTL_CLEAR);
        if (wdata[`DTC_CTL_START] && !start) load_q <= 1'b1;
      end
      if (clear_wr) begin
        cnt_q <= `DTC_ZERO;
        dir_q <= 1'b0;
        presc_q <= 7'h00;
      end
      for (k = 0; k < 2; k = k + 1) begin
        ch_ev_q[k] <= match[k] | capt[k];
        cc_out_q[k] <= out_d[k];
        if (capt[k]) cc_q[k*8 +: 8] <= cnt_q;
        // buffered value lands only while counter sits at zero
        if (pend_q[k] && cnt_q == `DTC_ZERO) begin
          cc_q[k*8 +: 8] <= buf_q[k*8 +: 8];
          pend_q[k] <= 1'b0;
        end
        if (cc_we[k]) begin
          if (cctl_q[k*8+`DTC_CCTL_MODE]) begin
            buf_q[k*8 +: 8] <= wdata;
            pend_q[k] <= 1'b1;
          end else begin
            cc_q[k*8 +: 8] <= wdata;
          end
        end
        if (cctl_we[k]) begin
          if (wdata[`DTC_CCTL_ACT_LSB +: 3] == `DTC_ACT_INIT) begin
            cctl_q[k*8 +: 8] <= (wdata & `DTC_CCTL_WMASK & 8'hC7) |
                                (cctl_q[k*8 +: 8] & 8'h38);
            cc_out_q[k] <= init_level(cctl_q[k*8+`DTC_CCTL_ACT_LSB +: 3]);
          end else begin
            cctl_q[k*8 +: 8] <= wdata & `DTC_CCTL_WMASK;
          end
        end
        if (clear_wr) cc_out_q[k] <= init_level(cctl_q[k*8+`DTC_CCTL_ACT_LSB +: 3]);
      end
    end
  end
endmodule

module dtc_top (
  // clock and reset
  input wire core_clk,
  input wire reset,
  // system tick enable, one cycle per tick
  input wire tick,
  // register port
  input wire [7:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  output reg [7:0] rdata_q,
  // channel pins, timer a ch0, ch1, timer b ch0, ch1
  input wire [3:0] cap_in,
  output wire [3:0] cc_out,
  // dma triggers
  output wire dma_trig_a_ch_zero,
  output wire dma_trig_a_ch_one,
  output wire dma_trig_b_ch_zero,
  output wire dma_trig_b_ch_one,
  // interrupt requests, one vector per timer
  output reg [1:0] irq_req_q
);
  reg [3:0] cap_s1_q;
  reg [3:0] cap_s2_q;
  reg [5:0] flag_q;
  reg [1:0] cpu_flag_q;
  reg [1:0] ien_q;
  reg gie_q;
  reg [5:0] flag_d;
  reg [1:0] cpu_d;
  reg [1:0] hw_set;
  reg [7:0] rd_mux;
  wire [7:0] a_cnt, a_ctl, b_cnt, b_ctl;
  wire [15:0] a_cctl, a_cc, b_cctl, b_cc;
  wire a_ovf, b_ovf;
  wire [1:0] a_ev, b_ev;
  wire [5:0] ev;
  wire [5:0] mask;

  dtc_timer u_a (
    .core_clk(core_clk),
    .reset(reset),
    .tick(tick),
    .wdata(wdata),
    .ctl_we(wr && addr == `DTC_A_CTL),
    .cctl_we({wr && addr == `DTC_A_CCTL1, wr && addr == `DTC_A_CCTL0}),
    .cc_we({wr && addr == `DTC_A_CC1, wr && addr == `DTC_A_CC0}),
    .cap_sync(cap_s2_q[1:0]),
    .cnt_q(a_cnt),
    .ctl_q(a_ctl),
    .cctl_q(a_cctl),
    .cc_q(a_cc),
    .ovf_q(a_ovf),
    .ch_ev_q(a_ev),
    .cc_out_q(cc_out[1:0])
  );

  dtc_timer u_b (
    .core_clk(core_clk),
    .reset(reset),
    .tick(tick),
    .wdata(wdata),
    .ctl_we(wr && addr == `DTC_B_CTL),
    .cctl_we({wr && addr == `DTC_B_CCTL1, wr && addr == `DTC_B_CCTL0}),
    .cc_we({wr && addr == `DTC_B_CC1, wr && addr == `DTC_B_CC0}),
    .cap_sync(cap_s2_q[3:2]),
    .cnt_q(b_cnt),
    .ctl_q(b_ctl),
    .cctl_q(b_cctl),
    .cc_q(b_cc),
    .ovf_q(b_ovf),
    .ch_ev_q(b_ev),
    .cc_out_q(cc_out[3:2])
  );

  assign dma_trig_a_ch_zero = a_ev[0];
  assign dma_trig_a_ch_one = a_ev[1];
  assign dma_trig_b_ch_zero = b_ev[0];
  assign dma_trig_b_ch_one = b_ev[1];
  assign ev = {b_ev, b_ovf, a_ev, a_ovf};
  assign mask = {b_cctl[8+`DTC_CCTL_MASK], b_cctl[`DTC_CCTL_MASK], b_ctl[`DTC_CTL_OVF_MASK],
                 a_cctl[8+`DTC_CCTL_MASK], a_cctl[`DTC_CCTL_MASK], a_ctl[`DTC_CTL_OVF_MASK]};

  // flag updates; hardware set wins over a software clear in the same cycle
  always @* begin
    flag_d = flag_q;
    if (wr && addr == `DTC_FLAG) flag_d = flag_q & wdata[5:0];
    flag_d = flag_d | ev;
    hw_set[0] = |(ev[2:0] & mask[2:0]);
    hw_set[1] = |(ev[5:3] & mask[5:3]);
    if (wr && addr == `DTC_FLAG) begin
      if (|(flag_q[2:0] & ~wdata[2:0]) && |(flag_q[2:0] & wdata[2:0] & mask[2:0]))
        hw_set[0] = 1'b1;
      if (|(flag_q[5:3] & ~wdata[5:3]) && |(flag_q[5:3] & wdata[5:3] & mask[5:3]))
        hw_set[1] = 1'b1;
    end
    cpu_d = cpu_flag_q;
    if (wr && addr == `DTC_CPU_FLAG) cpu_d = wdata[1:0];
    cpu_d = cpu_d | hw_set;
  end

  always @* begin
    case (addr)
      `DTC_A_CNT: rd_mux = a_cnt;
      `DTC_A_CTL: rd_mux = a_ctl;
      `DTC_A_CCTL0: rd_mux = a_cctl[7:0];
      `DTC_A_CC0: rd_mux = a_cc[7:0];
      `DTC_A_CCTL1: rd_mux = a_cctl[15:8];
      `DTC_A_CC1: rd_mux = a_cc[15:8];
      `DTC_B_CNT: rd_mux = b_cnt;
      `DTC_B_CTL: rd_mux = b_ctl;
      `DTC_B_CCTL0: rd_mux = b_cctl[7:0];
      `DTC_B_CC0: rd_mux = b_cc[7:0];
      `DTC_B_CCTL1: rd_mux = b_cctl[15:8];
      `DTC_B_CC1: rd_mux = b_cc[15:8];
      `DTC_FLAG: rd_mux = {2'b00, flag_q};
      `DTC_CPU_FLAG: rd_mux = {6'h00, cpu_flag_q};
      `DTC_IEN_ONE: rd_mux = {6'h00, ien_q};
      `DTC_IEN_ZERO: rd_mux = {gie_q, 7'h00};
      default: rd_mux = 8'h00;
    endcase
  end

  always @(posedge core_clk) begin
    if (reset) begin
      cap_s1_q <= 4'h0;
      cap_s2_q <= 4'h0;
      flag_q <= 6'h00;
      cpu_flag_q <= 2'b00;
      ien_q <= 2'b00;
      gie_q <= 1'b0;
      irq_req_q <= 2'b00;
      rdata_q <= 8'h00;
    end else begin
      // pins are asynchronous, so two stages before any edge logic
      cap_s1_q <= cap_in;
      cap_s2_q <= cap_s1_q;
      flag_q <= flag_d;
      cpu_flag_q <= cpu_d;
      if (wr && addr == `DTC_IEN_ONE) ien_q <= wdata[1:0];
      if (wr && addr == `DTC_IEN_ZERO) gie_q <= wdata[`DTC_GIE_BIT];
      irq_req_q <= cpu_d & ~cpu_flag_q & ien_q & {2{gie_q}};
      rdata_q <= rd ? rd_mux : 8'h00;
    end
  end
endmodule

// >>> dv/dtc_checker.sv
// port assertions for the dual 8-bit timer top
`timescale 1ns/1ps
module dtc_checker (
  // clock, reset and system tick
  input wire core_clk,
  input wire reset,
  input wire tick,
  // register port
  input wire [7:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  input wire [7:0] rdata_q,
  // pins and requests
  input wire [3:0] cc_out,
  input wire [1:0] irq_req_q
);
  reg gie_q;
  reg [1:0] ien_q;
  // enables shadowed from the bus, since the checker sees no registers
  always @(posedge core_clk) begin
    if (reset) begin
      gie_q <= 1'b0;
      ien_q <= 2'h0;
    end else if (wr && addr == 8'hA8) begin
      gie_q <= wdata[7];
    end else if (wr && addr == 8'hB8) begin
      ien_q <= wdata[1:0];
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  sequence s_rd(a);
    rd && addr == a;
  endsequence
  // no tick or clear may reach the counter between the two reads
  sequence s_cnt_hold;
    rd && addr == 8'hCA && !tick ##1 !tick && !wr ##1 rd && addr == 8'hCA;
  endsequence
  a_rdata_idle: assert property (!$past(rd) |-> rdata_q == 8'h00)
    else $error("read data outside its slot");
  a_clr_zero: assert property ((s_rd(8'hCB) or s_rd(8'hEB)) |=> !rdata_q[2])
    else $error("clear bit read back as one");
  a_resv_zero: assert property (s_rd(8'hCE) |=> !rdata_q[7])
    else $error("reserved channel bit read as one");
  a_unmapped_zero: assert property (s_rd(8'h00) |=> rdata_q == 8'h00)
    else $error("unmapped address returned data");
  a_irq_single: assert property (irq_req_q != 2'b00 |=> (irq_req_q & $past(irq_req_q)) == 2'b00)
    else $error("interrupt request longer than one cycle");
  a_irq_global: assert property (irq_req_q != 2'b00 |-> gie_q || $past(gie_q))
    else $error("interrupt request with global enable off");
  a_irq_enable: assert property (irq_req_q != 2'b00 |-> (irq_req_q & ~(ien_q | $past(ien_q))) == 2'b00)
    else $error("interrupt request with timer enable off");
  a_out_cause: assert property ($changed(cc_out) |-> $past(tick) || $past(tick, 2) || $past(wr) || $past(wr, 2))
    else $error("compare output moved without tick or write");
  a_cnt_hold: assert property (s_cnt_hold |=> rdata_q == $past(rdata_q, 2))
    else $error("counter moved without a tick");
endmodule

bind dtc_top dtc_checker chk (.core_clk(core_clk), .reset(reset), .tick(tick), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata_q(rdata_q), .cc_out(cc_out), .irq_req_q(irq_req_q));

// >>> dv/dtc_pins.sv
// far-side model of the four channel input pins
`timescale 1ns/1ps
module dtc_pins #(
  parameter SLOW = 0
) (
  input wire core_clk,
  input wire [3:0] pin_req,
  output reg [3:0] cap_in = 4'h0
);
  reg [3:0] lag_q = 4'h0;
  // levels only move at edges, so each lasts a full clock or more
  always @(posedge core_clk) begin
    lag_q <= pin_req;
    cap_in <= SLOW ? lag_q : pin_req;
  end
endmodule

// >>> dv/dtc_top_tb.sv
// self-checking bench for the dual 8-bit timer
`timescale 1ns/1ps
module dtc_top_tb;
  reg core_clk = 1'b0;
  reg reset = 1'b1;
  reg tick = 1'b0;
  reg [7:0] addr = 8'h00;
  reg [7:0] wdata = 8'h00;
  reg wr = 1'b0;
  reg rd = 1'b0;
  reg [3:0] pin_req = 4'h0;
  wire [7:0] rdata_q;
  wire [3:0] cap_in;
  wire [3:0] cc_out;
  wire [3:0] dma;
  wire [1:0] irq_req_q;
  integer errors = 0;
  integer n_checks = 0;
  integer cyc = 0;
  integer irq_a = 0;
  integer irq_b = 0;
  integer dma_a0 = 0;
  integer dma_a1 = 0;
  integer dma_b = 0;
  integer a;
  integer e;
  // start level per action code 0..6
  localparam [6:0] INIT_LV = 7'b1010010;
  always #10 core_clk = ~core_clk;
  dtc_top dut (.core_clk(core_clk), .reset(reset), .tick(tick), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata_q(rdata_q), .cap_in(cap_in), .cc_out(cc_out),
    .dma_trig_a_ch_zero(dma[0]), .dma_trig_a_ch_one(dma[1]), .dma_trig_b_ch_zero(dma[2]),
    .dma_trig_b_ch_one(dma[3]), .irq_req_q(irq_req_q));
  dtc_pins #(.SLOW(1)) pins (.core_clk(core_clk), .pin_req(pin_req), .cap_in(cap_in));
  task results;
    begin
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    irq_a <= irq_a + irq_req_q[0];
    irq_b <= irq_b + irq_req_q[1];
    dma_a0 <= dma_a0 + dma[0];
    dma_a1 <= dma_a1 + dma[1];
    dma_b <= dma_b + dma[2] + dma[3];
    if (cyc == 10000) begin
      errors = errors + 1;
      results;
    end
  end
  task chk(input [7:0] got, input [7:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("[FAIL] %0t got %h want %h", $time, got, exp);
      end
    end
  endtask
  task wreg(input [7:0] ad, input [7:0] d);
    begin
      @(posedge core_clk);
      addr <= ad;
      wdata <= d;
      wr <= 1'b1;
      @(posedge core_clk);
      wr <= 1'b0;
    end
  endtask
  task rreg(input [7:0] ad, input [7:0] m, input [7:0] exp);
    begin
      @(posedge core_clk);
      addr <= ad;
      rd <= 1'b1;
      @(posedge core_clk);
      rd <= 1'b0;
      #1;
      chk(rdata_q & m, exp);
    end
  endtask
  // idle edges after the burst let flags and outputs settle
  task ticks(input integer n);
    begin
      repeat (n) begin
        @(posedge core_clk);
        tick <= 1'b1;
      end
      @(posedge core_clk);
      tick <= 1'b0;
      repeat (3) @(posedge core_clk);
      #1;
    end
  endtask
  initial begin
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    rreg(8'hCB, 8'hFF, 8'h08);
    rreg(8'hCC, 8'hFF, 8'h40);
    rreg(8'hCA, 8'hFF, 8'h00);
    rreg(8'h00, 8'hFF, 8'h00);
    for (e = 0; e < 8; e = e + 1) begin
      wreg(8'hCB, {e[2:0], 5'h1C});
      ticks(3 << e);
      rreg(8'hCA, 8'hFF, 8'h03);
    end
    wreg(8'hB8, 8'h03);
    wreg(8'hA8, 8'h80);
    wreg(8'hD8, 8'h00);
    wreg(8'hCB, 8'h1C);
    wreg(8'hEB, 8'h1C);
    ticks(255);
    rreg(8'hCA, 8'hFF, 8'hFF);
    rreg(8'hEA, 8'hFF, 8'hFF);
    rreg(8'hD8, 8'h09, 8'h09);
    chk({irq_b[3:0], irq_a[3:0]}, 8'h11);
    ticks(1);
    rreg(8'hCA, 8'hFF, 8'h00);
    ticks(3);
    wreg(8'hCB, 8'h08);
    ticks(5);
    rreg(8'hCA, 8'hFF, 8'h03);
    rreg(8'hCA, 8'hFF, 8'h03);
    wreg(8'hCD, 8'h05);
    wreg(8'hCB, 8'h0D);
    wreg(8'hCB, 8'h19);
    wreg(8'hD8, 8'h00);
    ticks(3);
    rreg(8'hCA, 8'hFF, 8'h03);
    ticks(3);
    rreg(8'hD8, 8'h01, 8'h01);
    ticks(3);
    rreg(8'hCA, 8'hFF, 8'h00);
    wreg(8'hCD, 8'h03);
    wreg(8'hCB, 8'h1E);
    ticks(6);
    rreg(8'hCA, 8'hFF, 8'h02);
    wreg(8'hCB, 8'h1F);
    ticks(4);
    rreg(8'hCA, 8'hFF, 8'h02);
    wreg(8'hCB, 8'h1F);
    ticks(2);
    rreg(8'hCA, 8'hFF, 8'h02);
    wreg(8'hD8, 8'h00);
    ticks(4);
    rreg(8'hD8, 8'h01, 8'h01);
    wreg(8'hCB, 8'h1C);
    for (e = 1; e < 4; e = e + 1) begin
      wreg(8'hCC, {6'h10, e[1:0]});
      ticks(2);
      @(posedge core_clk) pin_req[0] <= ~pin_req[0];
      repeat (8) @(posedge core_clk);
      rreg(8'hCD, 8'hFF, {e[6:0], 1'b0});
    end
    chk(dma_a0[7:0], 8'h03);
    rreg(8'hD8, 8'h02, 8'h02);
    for (a = 0; a < 7; a = a + 1) begin
      wreg(8'hCE, {2'h1, a[2:0], 3'h4});
      wreg(8'hCE, 8'h7C);
      rreg(8'hCE, 8'hFF, {2'h1, a[2:0], 3'h4});
      chk({7'h0, cc_out[1]}, {7'h0, INIT_LV[a]});
      wreg(8'hCB, 8'h1C);
      wreg(8'hCF, 8'h04);
      ticks(4);
      chk({7'h0, cc_out[1]}, {7'h0, ~INIT_LV[a]});
      wreg(8'hCF, 8'h06);
      ticks(2);
      chk({7'h0, cc_out[1]}, {7'h0, ~INIT_LV[a]});
    end
    chk(dma_a1[7:0], 8'h07);
    wreg(8'hC0, 8'h00);
    wreg(8'hD8, 8'h3E);
    rreg(8'hC0, 8'h01, 8'h01);
    wreg(8'hCC, 8'h00);
    wreg(8'hCE, 8'h00);
    wreg(8'hCB, 8'h14);
    wreg(8'hD8, 8'h00);
    wreg(8'hC0, 8'h00);
    ticks(255);
    rreg(8'hD8, 8'h01, 8'h01);
    rreg(8'hC0, 8'h01, 8'h00);
    ticks(8);
    wreg(8'hD8, 8'h00);
    wreg(8'hCB, 8'h12);
    ticks(248);
    rreg(8'hCA, 8'hFF, 8'hFF);
    rreg(8'hD8, 8'h01, 8'h01);
    ticks(1);
    rreg(8'hCA, 8'hFF, 8'h00);
    wreg(8'hEB, 8'h1C);
    wreg(8'hEC, 8'h14);
    wreg(8'hEE, 8'h0C);
    wreg(8'hEE, 8'h3C);
    rreg(8'hEE, 8'hFF, 8'h0C);
    chk({6'h00, cc_out[3:2]}, 8'h02);
    wreg(8'hED, 8'h02);
    wreg(8'hEF, 8'h03);
    ticks(3);
    chk({6'h00, cc_out[3:2]}, 8'h01);
    chk(dma_b[7:0], 8'h02);
    results;
  end
endmodule
